// file: rtl/sacr_fifo.sv
/*
 * sacr_fifo: small synchronous fifo with valid/ready on both sides.
 * assumes one clock and a synchronous active-high reset.
 */
`timescale 1ns/1ps
module sacr_fifo #(
  parameter int unsigned WIDTH = 12,
  parameter int unsigned DEPTH = 4
) (
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [WIDTH-1:0] o_out_data
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0] wr_reg;
  logic [AW-1:0] rd_reg;
  logic [AW:0] count_reg;
  logic [AW:0] count_next;
  logic in_ready_reg;
  logic push;
  logic pop;

  // ready is registered so the top output comes straight from a flop
  assign push = i_in_valid && in_ready_reg;
  assign pop = i_out_ready && (count_reg != '0);
  assign count_next = count_reg + (AW+1)'(push) - (AW+1)'(pop);
  assign o_in_ready = in_ready_reg;
  assign o_out_valid = count_reg != '0;
  assign o_out_data = mem_reg[rd_reg];

  always_ff @(posedge i_core_clk) begin
    if (push) begin
      mem_reg[wr_reg] <= i_in_data;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      wr_reg <= '0;
      rd_reg <= '0;
      count_reg <= '0;
      in_ready_reg <= 1'b0;
    end else begin
      in_ready_reg <= count_next != (AW+1)'(DEPTH);
      if (push) begin
        wr_reg <= (wr_reg == AW'(DEPTH-1)) ? '0 : wr_reg + 1'b1;
      end
      if (pop) begin
        rd_reg <= (rd_reg == AW'(DEPTH-1)) ? '0 : rd_reg + 1'b1;
      end
      count_reg <= count_next;
    end
  end
endmodule : sacr_fifo

// file: rtl/sacr_pkg.sv
/*
 * sacr_pkg: shared types and constants for the serial converter readout block.
 * assumes a 200 MHz core clock; no other package dependencies.
 */
package sacr_pkg;
  localparam int unsigned CLK_PERIOD_PS = 5000;
  localparam int unsigned CONV_TIME_NS = 8500;
  localparam int unsigned CYCLE_TIME_NS = 10000;
  localparam int unsigned WAKE_DELAY_NS = 2000;
  localparam int unsigned CONV_CYCLES = (CONV_TIME_NS * 1000) / CLK_PERIOD_PS;
  localparam int unsigned CYCLE_CYCLES = (CYCLE_TIME_NS * 1000) / CLK_PERIOD_PS;
  localparam int unsigned WAKE_CYCLES = (WAKE_DELAY_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned RESULT_BITS = 12;
  localparam int unsigned FRAME_BITS = RESULT_BITS + 1;
  localparam int unsigned FIFO_DEPTH = 4;
  localparam int unsigned TIMER_BITS = 12;

  typedef logic [RESULT_BITS-1:0] sacr_result_type;

  typedef enum logic [1:0] {
    SACR_OFF = 2'b00,
    SACR_WAKE = 2'b01,
    SACR_READY = 2'b11,
    SACR_REF_EXT = 2'b10
  } sacr_power_type;

  typedef enum logic [1:0] {
    SACR_TRACK = 2'b00,
    SACR_CONVERT = 2'b01,
    SACR_SHIFT = 2'b11
  } sacr_state_type;

  typedef struct packed {
    logic dout;
    logic dout_oe;
  } sacr_serial_out_type;

  typedef struct packed {
    logic hold;
    logic ref_internal;
    logic operational;
  } sacr_analog_ctl_type;
endpackage : sacr_pkg

// file: rtl/sacr_top.sv
/*
 * sacr_top: conversion sequencing, power modes and serial readout
 * of a 12-bit successive-approximation converter with a three-wire port.
 * assumes select, serial clock and power-down levels arrive asynchronously;
 * results from the analog core arrive as a valid/ready stream through a fifo.
 */
`timescale 1ns/1ps
module sacr_top (
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  input wire logic i_select_n,
  input wire logic i_sclk,
  input wire logic i_power_down_n,
  input wire logic i_power_down_float,
  input wire logic i_sample_valid,
  output logic o_sample_ready,
  input wire sacr_pkg::sacr_result_type i_sample_data,
  output logic o_dout,
  output logic o_dout_oe,
  output logic o_hold,
  output logic o_ref_internal,
  output logic o_operational,
  output logic o_sample_req
);
  // ==========================================================
  // input synchronisers
  logic [2:0] sel_sync_reg;
  logic [2:0] sclk_sync_reg;
  logic [2:0] pdn_sync_reg;
  logic [2:0] flt_sync_reg;
  logic sel_reg;
  logic sclk_reg;
  logic pdn_reg;
  logic flt_reg;

  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      sel_sync_reg <= 3'h7;
      sclk_sync_reg <= 3'h0;
      pdn_sync_reg <= 3'h0;
      flt_sync_reg <= 3'h0;
    end else begin
      sel_sync_reg <= {sel_sync_reg[1:0], i_select_n};
      sclk_sync_reg <= {sclk_sync_reg[1:0], i_sclk};
      pdn_sync_reg <= {pdn_sync_reg[1:0], i_power_down_n};
      flt_sync_reg <= {flt_sync_reg[1:0], i_power_down_float};
    end
  end

  // filtered levels update only when stages two and three agree
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      sel_reg <= 1'b1;
      sclk_reg <= 1'b0;
      pdn_reg <= 1'b0;
      flt_reg <= 1'b0;
    end else begin
      if (sel_sync_reg[1] == sel_sync_reg[2]) begin
        sel_reg <= sel_sync_reg[2];
      end
      if (sclk_sync_reg[1] == sclk_sync_reg[2]) begin
        sclk_reg <= sclk_sync_reg[2];
      end
      if (pdn_sync_reg[1] == pdn_sync_reg[2]) begin
        pdn_reg <= pdn_sync_reg[2];
      end
      if (flt_sync_reg[1] == flt_sync_reg[2]) begin
        flt_reg <= flt_sync_reg[2];
      end
    end
  end

  logic sel_now;
  logic sclk_now;
  logic sel_fall;
  logic sclk_fall;
  assign sel_now = (sel_sync_reg[1] == sel_sync_reg[2]) ? sel_sync_reg[2] : sel_reg;
  assign sclk_now = (sclk_sync_reg[1] == sclk_sync_reg[2]) ? sclk_sync_reg[2] : sclk_reg;
  assign sel_fall = sel_reg && !sel_now;
  assign sclk_fall = sclk_reg && !sclk_now;

  // ==========================================================
  // power mode
  sacr_pkg::sacr_power_type power_reg;
  logic [sacr_pkg::TIMER_BITS-1:0] wake_reg;
  logic awake;
  logic pdn_high;
  assign pdn_high = pdn_reg || flt_reg;

  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      power_reg <= sacr_pkg::SACR_OFF;
      wake_reg <= '0;
    end else if (!pdn_high) begin
      power_reg <= sacr_pkg::SACR_OFF;
      wake_reg <= '0;
    end else begin
      unique case (power_reg)
        sacr_pkg::SACR_OFF: begin
          power_reg <= sacr_pkg::SACR_WAKE;
          wake_reg <= '0;
        end
        sacr_pkg::SACR_WAKE: begin
          wake_reg <= wake_reg + 1'b1;
          if (wake_reg == sacr_pkg::TIMER_BITS'(sacr_pkg::WAKE_CYCLES - 1)) begin
            power_reg <= sacr_pkg::SACR_READY;
          end
        end
        sacr_pkg::SACR_READY: begin
          power_reg <= sacr_pkg::SACR_READY;
        end
        default: begin
          power_reg <= sacr_pkg::SACR_OFF;
        end
      endcase
    end
  end
  assign awake = (power_reg == sacr_pkg::SACR_READY) && pdn_high;

  // ==========================================================
  // conversion sequencing and readout
  sacr_pkg::sacr_state_type state_reg;
  logic [sacr_pkg::TIMER_BITS-1:0] conv_reg;
  logic [sacr_pkg::FRAME_BITS-1:0] shift_reg;
  logic convert_done;
  assign convert_done = conv_reg == sacr_pkg::TIMER_BITS'(sacr_pkg::CONV_CYCLES - 1);

  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      state_reg <= sacr_pkg::SACR_TRACK;
      conv_reg <= '0;
    end else if (!awake || sel_now) begin
      state_reg <= sacr_pkg::SACR_TRACK;
      conv_reg <= '0;
    end else begin
      unique case (state_reg)
        sacr_pkg::SACR_TRACK: begin
          if (sel_fall) begin
            state_reg <= sacr_pkg::SACR_CONVERT;
            conv_reg <= '0;
          end
        end
        sacr_pkg::SACR_CONVERT: begin
          conv_reg <= conv_reg + 1'b1;
          if (convert_done) begin
            state_reg <= sacr_pkg::SACR_SHIFT;
          end
        end
        sacr_pkg::SACR_SHIFT: begin
          state_reg <= sacr_pkg::SACR_SHIFT;
        end
        default: begin
          state_reg <= sacr_pkg::SACR_TRACK;
        end
      endcase
    end
  end

  // fifo holding results from the analog core
  logic fifo_valid;
  logic fifo_pop;
  sacr_pkg::sacr_result_type fifo_data;
  assign fifo_pop = (state_reg == sacr_pkg::SACR_CONVERT) && convert_done && awake && !sel_now;

  sacr_fifo #(
    .WIDTH(sacr_pkg::RESULT_BITS),
    .DEPTH(sacr_pkg::FIFO_DEPTH)
  ) u_fifo (
    .i_core_clk(i_core_clk),
    .i_sys_rst(i_sys_rst),
    .i_in_valid(i_sample_valid),
    .o_in_ready(o_sample_ready),
    .i_in_data(i_sample_data),
    .o_out_valid(fifo_valid),
    .i_out_ready(fifo_pop),
    .o_out_data(fifo_data)
  );

  // output shift register
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      shift_reg <= '0;
    end else if (fifo_pop) begin
      shift_reg <= {1'b1, fifo_valid ? fifo_data : '0};
    end else if (state_reg == sacr_pkg::SACR_SHIFT && sclk_fall) begin
      shift_reg <= {shift_reg[sacr_pkg::FRAME_BITS-2:0], 1'b0};
    end
  end

  sacr_pkg::sacr_serial_out_type ser_next;
  always_comb begin
    ser_next.dout_oe = awake && !sel_now;
    ser_next.dout = 1'b0;
    if (state_reg == sacr_pkg::SACR_SHIFT) begin
      ser_next.dout = shift_reg[sacr_pkg::FRAME_BITS-1];
    end
    if (fifo_pop) begin
      ser_next.dout = 1'b1;
    end else if (state_reg == sacr_pkg::SACR_SHIFT && sclk_fall) begin
      ser_next.dout = shift_reg[sacr_pkg::FRAME_BITS-2];
    end
  end

  sacr_pkg::sacr_analog_ctl_type ana_next;
  always_comb begin
    ana_next.hold = (state_reg == sacr_pkg::SACR_CONVERT && !fifo_pop && awake && !sel_now)
      || (state_reg == sacr_pkg::SACR_TRACK && sel_fall && awake);
    ana_next.ref_internal = pdn_reg && !flt_reg;
    ana_next.operational = pdn_high;
  end

  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      o_dout <= 1'b0;
      o_dout_oe <= 1'b0;
      o_hold <= 1'b0;
      o_ref_internal <= 1'b0;
      o_operational <= 1'b0;
      o_sample_req <= 1'b0;
    end else begin
      o_dout <= ser_next.dout;
      o_dout_oe <= ser_next.dout_oe;
      o_hold <= ana_next.hold;
      o_ref_internal <= ana_next.ref_internal;
      o_operational <= ana_next.operational;
      o_sample_req <= state_reg == sacr_pkg::SACR_TRACK && sel_fall && awake;
    end
  end
endmodule : sacr_top

// file: verif/sacr_chk.sv
/* sacr_chk: port-level checks of sacr_top.
   assumes the core clock and synchronous reset of the top module. */
`timescale 1ns/1ps
module sacr_chk (
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  input wire logic i_select_n,
  input wire logic i_sclk,
  input wire logic i_power_down_n,
  input wire logic i_power_down_float,
  input wire logic o_dout,
  input wire logic o_dout_oe,
  input wire logic o_hold,
  input wire logic o_ref_internal,
  input wire logic o_operational,
  input wire logic o_sample_req
);
  // ==========
  // hold length counter
  logic [11:0] hold_cnt_reg;
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) hold_cnt_reg <= 12'h000;
    else hold_cnt_reg <= o_hold ? hold_cnt_reg + 12'h001 : 12'h000;
  end
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_sys_rst);
  start_holds_a: assert property ($rose(o_sample_req) |-> o_hold && o_dout_oe && !o_dout)
    else $error("start without hold");
  conv_time_a: assert property ($fell(o_hold) && o_dout |-> hold_cnt_reg == 12'h6a4)
    else $error("conversion length wrong");
  track_after_a: assert property ($rose(o_dout) && o_dout_oe |-> !o_hold)
    else $error("still holding at end");
  req_pulse_a: assert property (o_sample_req |=> !o_sample_req)
    else $error("start pulse too long");
  shut_quiet_a: assert property (!o_operational && !$past(o_operational) |-> !o_dout_oe)
    else $error("driving in shutdown");
  shut_pin_a: assert property ((!i_power_down_n && !i_power_down_float) [*7] |-> !o_operational)
    else $error("not shut down");
  float_ext_a: assert property (i_power_down_float [*7] |-> !o_ref_internal)
    else $error("reference on while floating");
  sel_hiz_a: assert property (i_select_n [*7] |-> !o_dout_oe)
    else $error("driving while deselected");
  sclk_hold_a: assert property ((i_sclk && o_dout_oe) [*7] |-> $stable(o_dout))
    else $error("data moved with clock high");
endmodule : sacr_chk
bind sacr_top sacr_chk i_chk (.i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst),
  .i_select_n(i_select_n), .i_sclk(i_sclk), .i_power_down_n(i_power_down_n),
  .i_power_down_float(i_power_down_float), .o_dout(o_dout), .o_dout_oe(o_dout_oe),
  .o_hold(o_hold), .o_ref_internal(o_ref_internal), .o_operational(o_operational),
  .o_sample_req(o_sample_req));

// file: verif/sacr_host_model.sv
/* sacr_host_model: host driving select and serial clock, reading data.
   assumes it alone drives select and clock. */
`timescale 1ns/1ps
module sacr_host_model (
  input wire logic i_dout,
  output logic o_select_n,
  output logic o_sclk
);
  // ==========
  // clock idle outside reads
  initial begin
    o_select_n = 1'b1;
    o_sclk = 1'b0;
  end
  task automatic sel(input logic v);
    o_select_n = v;
  endtask : sel
  // lead bit, then 15 falls; phases >= 100 ns
  task automatic read_frame(input int half, output logic [15:0] v);
    v[15] = i_dout;
    for (int i = 14; i >= 0; i--) begin
      o_sclk = 1'b1;
      #half;
      o_sclk = 1'b0;
      #half;
      v[i] = i_dout;
    end
  endtask : read_frame
endmodule : sacr_host_model

// file: verif/serial_adc_conversion_readout_tb_top.sv
/* serial_adc_conversion_readout_tb_top: directed bench for sacr_top.
   assumes a 200 MHz core clock and the host model on the serial port. */
`timescale 1ns/1ps
module serial_adc_conversion_readout_tb_top;
  logic i_core_clk;
  logic i_sys_rst;
  logic pdn, flt, s_valid;
  logic [11:0] s_data;
  wire select_n, sclk, dout_wire;
  logic s_ready, dout, dout_oe, hold, ref_int, oper, req;
  logic [15:0] frame;
  int n_mismatch = 0, compares = 0, cyc = 0, n_req = 0;
  always #2.5 i_core_clk = ~i_core_clk;
  assign dout_wire = dout_oe ? dout : 1'bz;
  sacr_top i_dut (.i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst), .i_select_n(select_n),
    .i_sclk(sclk), .i_power_down_n(pdn), .i_power_down_float(flt), .i_sample_valid(s_valid),
    .o_sample_ready(s_ready), .i_sample_data(s_data), .o_dout(dout), .o_dout_oe(dout_oe),
    .o_hold(hold), .o_ref_internal(ref_int), .o_operational(oper), .o_sample_req(req));
  sacr_host_model i_host (.i_dout(dout_wire), .o_select_n(select_n), .o_sclk(sclk));
  // ==========
  // helpers
  task automatic tick(input int n);
    repeat (n) @(posedge i_core_clk);
    #1;
  endtask : tick
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic stop_test;
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : stop_test
  always @(posedge i_core_clk) begin
    cyc++;
    if (req === 1'b1) n_req++;
    if (cyc == 40000) begin
      n_mismatch++;
      stop_test();
    end
  end
  task automatic conv(input logic [11:0] exp, input int half);
    int n;
    n = 0;
    i_host.sel(1'b0);
    while (req !== 1'b1 && n < 20) begin
      tick(1);
      n++;
    end
    check("start", {hold, dout_oe, dout}, 16'h0006);
    n = 0;
    while (dout !== 1'b1 && n < 2000) begin
      tick(1);
      n++;
    end
    check("conv cycles", n[15:0], 16'h06a4);
    check("track", hold, 16'h0000);
    i_host.read_frame(half, frame);
    check("frame", frame, {1'b1, exp, 3'h0});
    i_host.sel(1'b1);
    tick(10);
    check("release", dout_oe, 16'h0000);
    tick(300);
  endtask : conv
  // ==========
  // scenarios
  task automatic t_wake;
    int r;
    @(posedge i_core_clk) pdn <= 1'b1;
    tick(50);
    r = n_req;
    i_host.sel(1'b0);
    tick(30);
    check("wake refuse", {n_req != r, dout_oe}, 16'h0000);
    i_host.sel(1'b1);
    tick(450);
    check("awake", {oper, ref_int}, 16'h0003);
    $display("t_wake done");
  endtask : t_wake
  task automatic t_fifo;
    int n;
    logic [11:0] w;
    n = 0;
    w = 12'h8c1;
    @(posedge i_core_clk);
    s_valid <= 1'b1;
    s_data <= w;
    repeat (6) begin
      @(posedge i_core_clk);
      if (s_ready === 1'b1) begin
        n++;
        s_data <= w + 12'h111 * n[11:0];
      end
    end
    s_valid <= 1'b0;
    tick(1);
    check("fifo fill", {n[3:0], s_ready}, 16'h0008);
    for (int k = 0; k < 5; k++) begin
      conv(k < 4 ? w : 12'h000, (k % 2) ? 300 : 100);
      w = w + 12'h111;
    end
    $display("t_fifo done");
  endtask : t_fifo
  task automatic t_abort;
    i_host.sel(1'b0);
    tick(100);
    check("converting", {hold, dout}, 16'h0002);
    i_host.sel(1'b1);
    tick(10);
    check("abort", {dout_oe, hold}, 16'h0000);
    tick(300);
    $display("t_abort done");
  endtask : t_abort
  task automatic t_power;
    int r;
    @(posedge i_core_clk) flt <= 1'b1;
    tick(10);
    check("float", {oper, ref_int}, 16'h0002);
    @(posedge i_core_clk) flt <= 1'b0;
    pdn <= 1'b0;
    tick(10);
    check("shutdown", oper, 16'h0000);
    r = n_req;
    i_host.sel(1'b0);
    tick(30);
    check("shut refuse", {n_req != r, dout_oe, hold}, 16'h0000);
    i_host.sel(1'b1);
    $display("t_power done");
  endtask : t_power
  initial begin
    i_core_clk = 1'b0;
    i_sys_rst = 1'b1;
    pdn = 1'b0;
    flt = 1'b0;
    s_valid = 1'b0;
    s_data = 12'h000;
    repeat (10) @(posedge i_core_clk);
    // reference settling is modelled by the wake delay, which t_wake waits out before any conversion
    i_sys_rst <= 1'b0;
    tick(2);
    t_wake();
    t_fifo();
    t_abort();
    t_power();
    stop_test();
  end
endmodule : serial_adc_conversion_readout_tb_top
